// *** rtl/rlc_i2c_slave.sv ***
// Serial two-wire slave: address match, register index, write and read bytes.
`timescale 1ns/10ps
module rlc_i2c_slave (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Synchronised pins
  input  wire logic              scl,
  input  wire logic              sda,
  output logic                   sda_oe,
  // Address straps
  input  wire logic [2:0]        addr_strap,
  // Register side
  output rlc_pkg::rlc_reg_wr_t   reg_wr,
  output logic [7:0]             rd_idx,
  input  wire logic [7:0]        rd_data
);

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_INDEX, S_WDATA, S_RDATA, S_RACK} rlc_ph_t;

  typedef struct packed {
    rlc_ph_t    ph;
    logic       scl_d;
    logic       sda_d;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic       ack;
    logic       rd;
    logic [7:0] idx;
    logic       oe;
    rlc_pkg::rlc_reg_wr_t wr;
  } rlc_i2c_st_t;

  rlc_i2c_st_t st;
  rlc_i2c_st_t next_st;
  logic        rise;
  logic        fall;
  logic        start_c;
  logic        stop_c;

  assign rise    = scl & ~st.scl_d;
  assign fall    = ~scl & st.scl_d;
  assign start_c = scl & st.scl_d & st.sda_d & ~sda;
  assign stop_c  = scl & st.scl_d & ~st.sda_d & sda;

  always_comb
  begin
    next_st        = st;
    next_st.scl_d  = scl;
    next_st.sda_d  = sda;
    next_st.wr.wr  = 1'b0;
    if (start_c)
    begin
      next_st.ph   = S_ADDR;
      next_st.bitn = 4'h0;
      next_st.ack  = 1'b0;
      next_st.oe   = 1'b0;
    end
    else if (stop_c)
    begin
      next_st.ph = S_IDLE;
      next_st.oe = 1'b0;
    end
    else if (rise && st.ph != S_IDLE && st.ph != S_RACK && !st.ack)
    begin
      next_st.sh   = {st.sh[6:0], sda};
      next_st.bitn = st.bitn + 4'h1;
    end
    else if (rise && st.ph == S_RACK)
    begin
      // A not-acknowledge from the master ends the read burst.
      next_st.ph = sda ? S_IDLE : S_RDATA;
      // An acknowledge lets the next falling edge load the following byte.
      next_st.ack = ~sda;
    end
    else if (fall && st.ph != S_IDLE)
    begin
      if (st.ack)
      begin
        next_st.ack  = 1'b0;
        next_st.bitn = 4'h0;
        next_st.oe   = 1'b0;
        if (st.ph == S_RDATA)
        begin
          next_st.oe = ~rd_data[7];
          next_st.sh = rd_data;
        end
      end
      else if (st.ph == S_RDATA && st.bitn == 4'h8)
      begin
        next_st.oe  = 1'b0;
        next_st.ph  = S_RACK;
        next_st.idx = st.idx + 8'h01;
      end
      else if (st.ph == S_RDATA)
      begin
        // The byte shifts left on every rise, so the bit to drive next is always the top one.
        next_st.oe = ~st.sh[7];
      end
      else if (st.bitn == 4'h8)
      begin
        next_st.ack = 1'b1;
        next_st.oe  = 1'b1;
        case (st.ph)
          S_ADDR:
          begin
            // Only the strap-selected address is acknowledged.
            if (st.sh[7:1] == {rlc_pkg::SLAVE_ADDR_HIGH, addr_strap})
            begin
              next_st.rd = st.sh[0];
              next_st.ph = st.sh[0] ? S_RDATA : S_INDEX;
            end
            else
            begin
              next_st.ph  = S_IDLE;
              next_st.ack = 1'b0;
              next_st.oe  = 1'b0;
            end
          end
          S_INDEX:
          begin
            next_st.idx = st.sh;
            next_st.ph  = S_WDATA;
          end
          S_WDATA:
          begin
            next_st.wr.wr   = 1'b1;
            next_st.wr.idx  = st.idx;
            next_st.wr.data = st.sh;
            next_st.idx     = st.idx + 8'h01;
          end
          default:
          begin
            next_st.ph = S_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st       <= '0;
      st.ph    <= S_IDLE;
      st.scl_d <= 1'b1;
      st.sda_d <= 1'b1;
    end
    else
      st <= next_st;
  end

  // The first read byte is loaded at the acknowledge of the address.
  assign sda_oe = st.oe;
  assign reg_wr = st.wr;
  assign rd_idx = st.idx;

endmodule : rlc_i2c_slave

// *** rtl/rlc_pkg.sv ***
// Package of register map, field positions and shared types for the lane control register bank.
package rlc_pkg;

  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [7:0] GENERAL_SETTINGS_IDX   = 8'h00;
  localparam logic [7:0] LANE_ENABLE_IDX        = 8'h01;
  localparam logic [7:0] LANE0_GAIN_CONTROL_IDX = 8'h02;
  localparam logic [7:0] LANE0_STAGE_ENABLE_IDX = 8'h03;

  // ----------------------------------------
  // Reset values and writable masks
  // ----------------------------------------
  localparam logic [7:0] GENERAL_SETTINGS_RST   = 8'h00;
  localparam logic [7:0] LANE_ENABLE_RST        = 8'h00;
  localparam logic [7:0] LANE0_GAIN_CONTROL_RST = 8'h00;
  localparam logic [7:0] LANE0_STAGE_ENABLE_RST = 8'h00;
  localparam logic [7:0] LANE_ENABLE_MASK       = 8'h0F;
  localparam logic [7:0] LANE0_STAGE_MASK       = 8'h07;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CONTROL_SOURCE_BIT   = 7;
  localparam int SLEEP_REQUEST_BIT    = 6;
  localparam int TRACK_LANE01_BIT     = 5;
  localparam int TRACK_LANE23_BIT     = 4;
  localparam int TRACK_ALL_BIT        = 3;
  localparam int EQ_PROFILE_BIT       = 2;
  localparam int EQ_LEVEL_LSB         = 4;
  localparam int TX_GAIN_BIT          = 3;
  localparam int EQUALIZER_DC_GAIN_BIT       = 2;
  localparam int INPUT_GAIN_LSB       = 0;
  localparam int DRIVER_PEAK_BIT      = 2;
  localparam int EQ_STAGE_DIS_BIT     = 1;
  localparam int DRIVER_DIS_BIT       = 0;

  // ----------------------------------------
  // Serial address
  // ----------------------------------------
  localparam logic [3:0] SLAVE_ADDR_HIGH = 4'h0;

  // ----------------------------------------
  // Shared types
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] equalizer_level;
    logic       tx_gain_6db;
    logic       equalizer_dc_gain;
    logic [1:0] input_gain;
    logic       driver_peaking_on;
    logic       equalizer_stage_disable;
    logic       output_driver_disable;
  } rlc_lane_cfg_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] idx;
    logic [7:0] data;
  } rlc_reg_wr_t;

endpackage : rlc_pkg

// *** rtl/rlc_sync.sv ***
// Two-stage synchroniser for the serial pins and the address straps.
`timescale 1ns/10ps
module rlc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rlc_sync_st_t;

  rlc_sync_st_t st;
  rlc_sync_st_t next_st;

  // Pins idle high, so both stages reset to ones.
  always_comb
  begin
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      st <= '1;
    else
      st <= next_st;
  end

  assign sync_out = st.s2;

endmodule : rlc_sync

// *** rtl/rlc_lane_ctrl.sv ***
// Top of the lane control register bank: serial slave, registers and lane setting resolution.
// Behaviour
// - General bit 7 picks settings source: 0 serial registers, 1 strap pins.
// - General bit 6 set requests power-down; clear keeps normal operation.
// - General bit 5 clear makes lane 0 copy lane 1 settings.
// - General bit 4 clear makes lane 3 copy lane 2 settings.
// - General bit 3 clear makes lanes 0 and 3 copy lane 1 settings.
// - Global tracking overrides both pairwise tracking bits.
// - Lane enable bits 3..0 disable lanes when one; bits 7..4 read-only.
// - Lane 0 equalizer level bits 6..4, 000 weakest, 111 strongest.
// - Lane 0 control bit 3 gives transmit DC gain 0 dB or 6 dB.
// - Lane 0 control bit 2 gives equalizer DC gain -6 dB or 0 dB.
// - Lane 0 control bits 1..0 act as lane 0 input gain strap.
// - Lane 0 enable bit 2 turns on 6 dB driver peaking.
// - Lane 0 enable bit 1 disables lane 0 equalizer stage.
// - Lane 0 enable bit 0 disables lane 0 output driver.
// - General settings register resets to all zeros.
// - Device answers address 0000 plus three strap bits.
`timescale 1ns/10ps
module rlc_lane_ctrl (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Serial bus pins
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  // Address straps
  input  wire logic [2:0]            addr_strap,
  // Strap-pin settings for lane 0
  input  wire rlc_pkg::rlc_lane_cfg_t strap_lane_cfg,
  // Settings from the lane 1 control registers, kept outside this bank
  input  wire rlc_pkg::rlc_lane_cfg_t lane1_cfg,
  // Settings from the lane 2 control registers, kept outside this bank
  input  wire rlc_pkg::rlc_lane_cfg_t lane2_cfg,
  // Settings from the lane 3 control registers, kept outside this bank
  input  wire rlc_pkg::rlc_lane_cfg_t lane3_cfg,
  // Device controls
  output logic                       control_source_select,
  output logic                       sleep_request,
  output logic                       equalizer_profile_select,
  output logic [3:0]                 lane_disable,
  output rlc_pkg::rlc_lane_cfg_t     lane0_eff_cfg,
  output rlc_pkg::rlc_lane_cfg_t     lane3_eff_cfg
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] pins_s;

  rlc_sync #(
    .W (5)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({scl_in, sda_in, addr_strap}),
    .sync_out (pins_s)
  );

  // ----------------------------------------
  // Serial slave
  // ----------------------------------------
  rlc_pkg::rlc_reg_wr_t reg_wr;
  logic [7:0]           rd_idx;
  logic [7:0]           rd_data;

  rlc_i2c_slave u_slave (
    .core_clk   (core_clk),
    .rst        (rst),
    .scl        (pins_s[4]),
    .sda        (pins_s[3]),
    .sda_oe     (sda_oe),
    .addr_strap (pins_s[2:0]),
    .reg_wr     (reg_wr),
    .rd_idx     (rd_idx),
    .rd_data    (rd_data)
  );

  // Open-drain: the pin is only ever pulled low.
  assign sda_out = 1'b0;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] general_settings;
    logic [7:0] lane_enable;
    logic [7:0] lane0_gain_control;
    logic [7:0] lane0_stage_enable;
  } rlc_regs_t;

  rlc_regs_t st;
  rlc_regs_t next_st;

  always_comb
  begin
    next_st = st;
    if (reg_wr.wr)
    begin
      case (reg_wr.idx)
        rlc_pkg::GENERAL_SETTINGS_IDX:   next_st.general_settings   = reg_wr.data;
        rlc_pkg::LANE_ENABLE_IDX:        next_st.lane_enable        = reg_wr.data & rlc_pkg::LANE_ENABLE_MASK;
        rlc_pkg::LANE0_GAIN_CONTROL_IDX: next_st.lane0_gain_control = reg_wr.data;
        rlc_pkg::LANE0_STAGE_ENABLE_IDX: next_st.lane0_stage_enable = reg_wr.data & rlc_pkg::LANE0_STAGE_MASK;
        default:                         next_st = st;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st.general_settings   <= rlc_pkg::GENERAL_SETTINGS_RST;
      st.lane_enable        <= rlc_pkg::LANE_ENABLE_RST;
      st.lane0_gain_control <= rlc_pkg::LANE0_GAIN_CONTROL_RST;
      st.lane0_stage_enable <= rlc_pkg::LANE0_STAGE_ENABLE_RST;
    end
    else
      st <= next_st;
  end

  // Unmapped indices read as zero.
  always_comb
  begin
    case (rd_idx)
      rlc_pkg::GENERAL_SETTINGS_IDX:   rd_data = st.general_settings;
      rlc_pkg::LANE_ENABLE_IDX:        rd_data = st.lane_enable;
      rlc_pkg::LANE0_GAIN_CONTROL_IDX: rd_data = st.lane0_gain_control;
      rlc_pkg::LANE0_STAGE_ENABLE_IDX: rd_data = st.lane0_stage_enable;
      default:                         rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Lane setting resolution
  // ----------------------------------------
  rlc_pkg::rlc_lane_cfg_t lane0_own;
  rlc_pkg::rlc_lane_cfg_t lane1_src;
  logic                   track_01;
  logic                   track_23;
  logic                   track_all;

  assign lane0_own.equalizer_level         = st.lane0_gain_control[rlc_pkg::EQ_LEVEL_LSB +: 3];
  assign lane0_own.tx_gain_6db             = st.lane0_gain_control[rlc_pkg::TX_GAIN_BIT];
  assign lane0_own.equalizer_dc_gain       = st.lane0_gain_control[rlc_pkg::EQUALIZER_DC_GAIN_BIT];
  assign lane0_own.input_gain              = st.lane0_gain_control[rlc_pkg::INPUT_GAIN_LSB +: 2];
  assign lane0_own.driver_peaking_on       = st.lane0_stage_enable[rlc_pkg::DRIVER_PEAK_BIT];
  assign lane0_own.equalizer_stage_disable = st.lane0_stage_enable[rlc_pkg::EQ_STAGE_DIS_BIT];
  assign lane0_own.output_driver_disable   = st.lane0_stage_enable[rlc_pkg::DRIVER_DIS_BIT];

  assign track_all = ~st.general_settings[rlc_pkg::TRACK_ALL_BIT];
  assign track_01  = ~st.general_settings[rlc_pkg::TRACK_LANE01_BIT];
  assign track_23  = ~st.general_settings[rlc_pkg::TRACK_LANE23_BIT];

  // Strap mode puts lane 0 on the strap pins and keeps lane 3 on its own settings, with no tracking.
  always_comb
  begin
    lane1_src = lane1_cfg;
    if (control_source_select)
    begin
      lane0_eff_cfg = strap_lane_cfg;
      lane3_eff_cfg = lane3_cfg;
    end
    else if (track_all)
    begin
      lane0_eff_cfg = lane1_src;
      lane3_eff_cfg = lane1_src;
    end
    else
    begin
      lane0_eff_cfg = track_01 ? lane1_src : lane0_own;
      lane3_eff_cfg = track_23 ? lane2_cfg : lane3_cfg;
    end
  end

  // ----------------------------------------
  // Device controls
  // ----------------------------------------
  assign control_source_select    = st.general_settings[rlc_pkg::CONTROL_SOURCE_BIT];
  assign sleep_request            = st.general_settings[rlc_pkg::SLEEP_REQUEST_BIT];
  assign equalizer_profile_select = st.general_settings[rlc_pkg::EQ_PROFILE_BIT];
  assign lane_disable             = st.lane_enable[3:0];

endmodule : rlc_lane_ctrl

// *** test/rlc_lane_ctrl_asserts.sv ***
// Concurrent checks on the ports of the lane control register bank.
`timescale 1ns/10ps
module rlc_lane_ctrl_chk (
  // Clock and reset
  input wire logic                   core_clk,
  input wire logic                   rst,
  // Serial pins
  input wire logic                   scl_in,
  input wire logic                   sda_oe,
  // Lane inputs
  input wire rlc_pkg::rlc_lane_cfg_t strap_lane_cfg,
  input wire rlc_pkg::rlc_lane_cfg_t lane1_cfg,
  input wire rlc_pkg::rlc_lane_cfg_t lane2_cfg,
  input wire rlc_pkg::rlc_lane_cfg_t lane3_cfg,
  // Device controls
  input wire logic                   control_source_select,
  input wire logic                   sleep_request,
  input wire logic                   equalizer_profile_select,
  input wire logic [3:0]             lane_disable,
  input wire rlc_pkg::rlc_lane_cfg_t lane0_eff_cfg,
  input wire rlc_pkg::rlc_lane_cfg_t lane3_eff_cfg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_reset_values;
    $fell(rst) |-> !control_source_select && !sleep_request && !equalizer_profile_select && lane_disable == 4'h0
      && !sda_oe;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("controls not cleared by reset");

  property p_reset_tracking;
    $fell(rst) |-> lane0_eff_cfg == lane1_cfg && lane3_eff_cfg == lane1_cfg;
  endproperty
  a_reset_tracking: assert property (p_reset_tracking)
    else $error("lanes not tracking lane 1 after reset");

  property p_strap_lane0;
    control_source_select |-> lane0_eff_cfg == strap_lane_cfg;
  endproperty
  a_strap_lane0: assert property (p_strap_lane0)
    else $error("lane 0 not on strap settings");

  property p_strap_lane3;
    control_source_select |-> lane3_eff_cfg == lane3_cfg;
  endproperty
  a_strap_lane3: assert property (p_strap_lane3)
    else $error("lane 3 not on its own settings in strap mode");

  property p_global_first;
    !control_source_select && lane0_eff_cfg != lane1_cfg |-> lane3_eff_cfg == lane2_cfg || lane3_eff_cfg == lane3_cfg;
  endproperty
  a_global_first: assert property (p_global_first)
    else $error("lane 3 tracks lane 1 while lane 0 does not");

  // Registers may only move in the acknowledge slot, which lies in a low phase of the serial clock.
  property p_write_in_low;
    $changed({control_source_select, sleep_request, equalizer_profile_select, lane_disable}) |-> !scl_in;
  endproperty
  a_write_in_low: assert property (p_write_in_low)
    else $error("register changed while serial clock high");

  property p_ack_rise_low;
    $rose(sda_oe) |-> !scl_in && !$past(scl_in, 2);
  endproperty
  a_ack_rise_low: assert property (p_ack_rise_low)
    else $error("data pulled low outside a clock low phase");

  property p_oe_steady_high;
    scl_in && $past(scl_in) |-> $stable(sda_oe);
  endproperty
  a_oe_steady_high: assert property (p_oe_steady_high)
    else $error("data drive changed while serial clock high");
endmodule : rlc_lane_ctrl_chk

bind rlc_lane_ctrl rlc_lane_ctrl_chk u_rlc_lane_ctrl_chk (.core_clk, .rst, .scl_in, .sda_oe, .strap_lane_cfg,
  .lane1_cfg, .lane2_cfg, .lane3_cfg, .control_source_select, .sleep_request, .equalizer_profile_select,
  .lane_disable, .lane0_eff_cfg, .lane3_eff_cfg);

// *** test/rlc_i2c_master.sv ***
// Serial bus master model that reaches the register bank.
`timescale 1ns/10ps
module rlc_i2c_master (
  // Clock
  input wire logic core_clk,
  // Serial pins
  input wire logic sda_line,
  output logic     scl,
  output logic     sda_low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_cycles

  // Data moves five cycles, a fifth of a bit, after the clock falls, so no edge is mistaken for a start or stop.
  task automatic send_bit(input logic b, output logic r);
    sda_low = !b;
    wait_cycles(10);
    scl = 1'b1;
    wait_cycles(10);
    r = sda_line;
    scl = 1'b0;
    wait_cycles(5);
  endtask : send_bit

  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_out);
    for (int i = 7; i >= 0; i--)
      send_bit(d[i], q[i]);
    send_bit(ack_in, ack_out);
  endtask : xfer

  task automatic start_cond;
    sda_low = 1'b0;
    wait_cycles(5);
    scl = 1'b1;
    wait_cycles(10);
    sda_low = 1'b1;
    wait_cycles(10);
    scl = 1'b0;
    wait_cycles(5);
  endtask : start_cond

  task automatic stop_cond;
    sda_low = 1'b1;
    wait_cycles(5);
    scl = 1'b1;
    wait_cycles(10);
    sda_low = 1'b0;
    wait_cycles(10);
  endtask : stop_cond

  task automatic write_reg(input logic [6:0] addr, input logic [7:0] idx, input logic [7:0] data, output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    start_cond;
    xfer({addr, 1'b0}, 1'b1, q, a0);
    xfer(idx, 1'b1, q, a1);
    xfer(data, 1'b1, q, a2);
    stop_cond;
    ok = !a0 && !a1 && !a2;
  endtask : write_reg

  task automatic read_reg(input logic [6:0] addr, input logic [7:0] idx, output logic [7:0] data, output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    start_cond;
    xfer({addr, 1'b0}, 1'b1, q, a0);
    xfer(idx, 1'b1, q, a1);
    start_cond;
    xfer({addr, 1'b1}, 1'b1, q, a2);
    xfer(8'hFF, 1'b1, data, a3);
    stop_cond;
    ok = !a0 && !a1 && !a2;
  endtask : read_reg
endmodule : rlc_i2c_master

// *** test/tb_top.sv ***
// Self-checking bench of the lane control register bank.
`timescale 1ns/10ps
module tb_top;
  logic                   core_clk;
  logic                   rst;
  logic                   scl_in;
  logic                   sda_low;
  logic                   sda_oe;
  logic                   sda_out;
  wire logic              sda_in;
  logic [2:0]             addr_strap;
  logic [6:0]             dev_addr;
  rlc_pkg::rlc_lane_cfg_t strap_lane_cfg;
  rlc_pkg::rlc_lane_cfg_t lane1_cfg;
  rlc_pkg::rlc_lane_cfg_t lane2_cfg;
  rlc_pkg::rlc_lane_cfg_t lane3_cfg;
  rlc_pkg::rlc_lane_cfg_t lane0_eff_cfg;
  rlc_pkg::rlc_lane_cfg_t lane3_eff_cfg;
  logic                   control_source_select;
  logic                   sleep_request;
  logic                   equalizer_profile_select;
  logic [3:0]             lane_disable;
  int                     miscompares = 0;
  int                     checks = 0;
  int                     cycles = 0;

  // The data line has a pull-up, so it reads high unless someone pulls it low.
  assign sda_in = !sda_low && (!sda_oe || sda_out);

  rlc_lane_ctrl u_rlc_lane_ctrl (.core_clk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe, .addr_strap, .strap_lane_cfg,
    .lane1_cfg, .lane2_cfg, .lane3_cfg, .control_source_select, .sleep_request, .equalizer_profile_select,
    .lane_disable, .lane0_eff_cfg, .lane3_eff_cfg);
  rlc_i2c_master u_rlc_i2c_master (.core_clk, .sda_line(sda_in), .scl(scl_in), .sda_low);

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = !core_clk;
  end

  task automatic conclude;
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      conclude;
    end
  end

  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    logic ok;
    u_rlc_i2c_master.write_reg(dev_addr, idx, data, ok);
    check(10'(ok), 10'h001);
  endtask : wr

  task automatic rd_check(input logic [7:0] idx, input logic [7:0] exp);
    logic       ok;
    logic [7:0] q;
    u_rlc_i2c_master.read_reg(dev_addr, idx, q, ok);
    check(10'(ok), 10'h001);
    check(10'(q), 10'(exp));
  endtask : rd_check

  task automatic test_reset;
    check(10'({control_source_select, sleep_request, equalizer_profile_select, lane_disable}), 10'h000);
    check(lane3_eff_cfg, lane1_cfg);
    for (int i = 0; i < 4; i++)
      rd_check(8'(i), 8'h00);
  endtask : test_reset

  task automatic test_general;
    logic [7:0] v;
    for (int i = 0; i < 8; i++)
    begin
      v = 8'h01 << i;
      wr(8'h00, v);
      rd_check(8'h00, v);
      check(10'({control_source_select, sleep_request, equalizer_profile_select}), 10'({v[7], v[6], v[2]}));
    end
  endtask : test_general

  task automatic test_tracking;
    logic [7:0] gen [4] = '{8'h00, 8'h30, 8'h08, 8'h38};
    wr(8'h02, 8'hDB);
    wr(8'h03, 8'hFD);
    rd_check(8'h02, 8'hDB);
    rd_check(8'h03, 8'h05);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, gen[i]);
      check(lane0_eff_cfg, (i == 3) ? 10'h2DD : lane1_cfg);
      check(lane3_eff_cfg, (i < 2) ? lane1_cfg : (i == 2) ? lane2_cfg : lane3_cfg);
    end
    wr(8'h02, 8'h75);
    wr(8'h03, 8'h02);
    check(lane0_eff_cfg, 10'h3AA);
    wr(8'h00, 8'h80);
    check(lane0_eff_cfg, strap_lane_cfg);
    check(lane3_eff_cfg, lane3_cfg);
  endtask : test_tracking

  task automatic test_lane_enable;
    logic [7:0] v [2] = '{8'hFA, 8'h05};
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h01, v[i]);
      check(10'(lane_disable), 10'(v[i][3:0]));
      rd_check(8'h01, {4'h0, v[i][3:0]});
    end
  endtask : test_lane_enable

  task automatic test_address;
    logic ok;
    wr(8'h00, 8'h00);
    addr_strap = 3'b101;
    repeat (4) @(negedge core_clk);
    u_rlc_i2c_master.write_reg(7'h00, 8'h00, 8'h40, ok);
    check(10'(ok), 10'h000);
    check(10'(sleep_request), 10'h000);
    dev_addr = 7'h05;
    wr(8'h00, 8'h40);
    check(10'(sleep_request), 10'h001);
    wr(8'h10, 8'hFF);
    rd_check(8'h10, 8'h00);
    rd_check(8'h00, 8'h40);
  endtask : test_address

  initial
  begin
    rst = 1'b1;
    addr_strap = 3'b000;
    dev_addr = 7'h00;
    strap_lane_cfg = 10'h0F0;
    lane1_cfg = 10'h2A5;
    lane2_cfg = 10'h14A;
    lane3_cfg = 10'h3C3;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    test_reset;
    test_general;
    test_tracking;
    test_lane_enable;
    test_address;
    conclude;
  end
endmodule : tb_top
